//--- test/swr_master_model.sv
// Bus master model for the single-wire ROM slave: drives the pull-low enable.
// Assumes the bench resolves the wire with a pull-up and calls these tasks.
`timescale 1ns/1ps
`default_nettype none
module swr_master_model (
  input wire logic clk,
  input wire logic dq,
  output var logic m_oe
);
  initial m_oe = 1'b0;

  // The master starts every pulse; only its low length tells reset from slot
  task automatic bus_reset(input logic f, input int len, output logic pres);
    int i;
    pres = 1'b0;
    m_oe = 1'b1;
    // Edges here are sharp, so the low length needs no fall-time margin
    repeat (len) @(negedge clk);
    m_oe = 1'b0;
    // Window covers presence delay, presence low and recovery
    for (i = 0; i < (f ? 400 : 3200); i++) begin
      if (i == (f ? 150 : 1500)) pres = !dq;
      @(negedge clk);
    end
  endtask

  // A write-one slot doubles as a read slot; write-zero holds past the sample point
  task automatic slot(input logic f, input logic b, output logic r);
    int i;
    int lw;
    lw = b ? (f ? 2 : 10) : (f ? 70 : 610);
    r = 1'b1;
    m_oe = 1'b1;
    // Total slot length leaves recovery after the device lets go
    for (i = 0; i < (f ? 85 : 620); i++) begin
      if (i == lw) m_oe = 1'b0;
      if (i == (f ? 20 : 40)) r = dq;
      @(negedge clk);
    end
  endtask
endmodule
`default_nettype wire

//--- test/swr_rom_slave_tb.sv
// Self-checking bench for the single-wire ROM slave with one master model.
// Assumes the slave's timing figures at a 50 ns clock and a pulled-up wire.
`timescale 1ns/1ps
`default_nettype none
module swr_rom_slave_tb;
  localparam logic [7:0] FAM = 8'h2d; // Arbitrary value
  localparam logic [47:0] SER = 48'h9e3b71c0a455; // Arbitrary value
  logic clk, nrst, ce, m_oe, dq_o, dq_oe, fast_flag, p, r, r2;
  wire dq;
  logic [15:0] lfsr_reg;
  logic [63:0] rom, got;
  logic [7:0] cmd;
  int error_cnt, n_compared, cyc, i, k;

  // Single slave only, so the wired-AND never merges replies
  assign dq = !(m_oe || (dq_oe && !dq_o));

  swr_rom_slave #(.FAMILY_CODE(FAM), .SERIAL_NUMBER(SER), .STD_RST_CYC(1000)) dut_u (
    .clk(clk), .nrst(nrst), .ce(ce), .dq_i(dq), .dq_o(dq_o), .dq_oe(dq_oe),
    .fast_speed_flag(fast_flag));
  swr_master_model master_u (.clk(clk), .dq(dq), .m_oe(m_oe));

  function automatic logic [63:0] rom_of(input logic [7:0] fam, input logic [47:0] ser);
    logic [7:0] c;
    logic [55:0] d;
    d = {ser, fam};
    c = 8'h00;
    for (int j = 0; j < 56; j++) c = (c >> 1) ^ ((c[0] ^ d[j]) ? 8'h8c : 8'h00);
    return {c, d};
  endfunction

  function automatic logic [15:0] lfsr_next(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction

  task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic send_byte(input logic f, input logic [7:0] b);
    logic x;
    for (int j = 0; j < 8; j++) master_u.slot(f, b[j], x);
  endtask

  task report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Worst case of the sequence below stays near 90k cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 100000) begin
      error_cnt++;
      report_and_stop();
    end
  end

  initial begin
    nrst = 1'b0;
    ce = 1'b1;
    lfsr_reg = 16'h0010;
    error_cnt = 0;
    n_compared = 0;
    cyc = 0;
    rom = rom_of(FAM, SER);
    repeat (2) @(negedge clk);
    nrst = 1'b1;
    repeat (3) @(negedge clk);
    master_u.slot(1'b0, 1'b1, r);
    check("slot before presence", 64'(r), 64'h1);
    master_u.bus_reset(1'b0, 1010, p);
    check("presence std", 64'(p), 64'h1);
    check("flag after power up", 64'(fast_flag), 64'h0);
    send_byte(1'b0, 8'h33);
    for (i = 0; i < 64; i++) begin
      master_u.slot(1'b0, 1'b1, r);
      got[i] = r;
    end
    check("read number", got, rom);
    master_u.slot(1'b0, 1'b1, r);
    check("slot after number", 64'(r), 64'h1);
    master_u.bus_reset(1'b0, 1010, p);
    send_byte(1'b0, 8'h3c);
    check("flag after skip", 64'(fast_flag), 64'h1);
    master_u.bus_reset(1'b1, 980, p);
    check("presence fast", 64'(p), 64'h1);
    check("flag after short reset", 64'(fast_flag), 64'h1);
    // Drop out at a random position by writing the complement there
    lfsr_reg = lfsr_next(lfsr_reg);
    k = int'(lfsr_reg[5:0]);
    send_byte(1'b1, 8'hf0);
    for (i = 0; i < 64 && i < k + 3; i++) begin
      master_u.slot(1'b1, 1'b1, r);
      master_u.slot(1'b1, 1'b1, r2);
      got = (i > k) ? 64'h3 : 64'({rom[i], !rom[i]});
      check("search pair", 64'({r, r2}), got);
      master_u.slot(1'b1, (i == k) ? !rom[i] : rom[i], r);
    end
    for (i = 0; i < 3; i++) begin
      lfsr_reg = lfsr_next(lfsr_reg);
      cmd = lfsr_reg[7:0];
      if (cmd == 8'h33 || cmd == 8'hf0 || cmd == 8'h3c) cmd = 8'h55;
      master_u.bus_reset(1'b1, 980, p);
      send_byte(1'b1, cmd);
      // A reading or searching device would pull some of these eight slots low
      for (k = 0; k < 8; k++) begin
        master_u.slot(1'b1, 1'b1, r);
        got[k] = r;
      end
      check("slots after unknown command", 64'(got[7:0]), 64'hff);
    end
    master_u.bus_reset(1'b0, 1010, p);
    check("flag after long reset", 64'(fast_flag), 64'h0);
    check("presence back at std", 64'(p), 64'h1);
    report_and_stop();
  end
endmodule
`default_nettype wire

//--- verilog/swr_pkg.sv
// Types shared by the single-wire ROM slave.
// Assumes nothing beyond a SystemVerilog compiler.
package swr_pkg;
  typedef enum logic [1:0] {
    SWR_M_DEAD = 2'b00,
    SWR_M_CMD = 2'b01,
    SWR_M_READ = 2'b10,
    SWR_M_SEARCH = 2'b11
  } swr_mode_e;

  typedef enum logic [1:0] {
    SWR_PH_IDLE = 2'b00,
    SWR_PH_LOW = 2'b01,
    SWR_PH_PWAIT = 2'b10,
    SWR_PH_PDRIVE = 2'b11
  } swr_phase_e;

  typedef struct packed {
    logic sync1;
    logic sync2;
    logic prev;
    logic oe;
    logic fast;
    swr_mode_e mode;
    swr_phase_e ph;
    logic [15:0] cnt;
    logic [5:0] bitn;
    logic [1:0] tri_pos;
    logic [7:0] cmd;
  } swr_state_s;
endpackage

//--- verilog/swr_regs.svh
// Timing figures and codes for the single-wire ROM slave.
// Assumes a 50 ns system clock; all times below are in nanoseconds.
`ifndef SWR_REGS_SVH
`define SWR_REGS_SVH

`define SWR_CLK_NS 50
`define SWR_CYC_UP(ns) (((ns) + `SWR_CLK_NS - 1) / `SWR_CLK_NS)

`define SWR_RESET_LOW_STD_NS 480000
`define SWR_RESET_LOW_OD_MAX_NS 80000
`define SWR_RESET_LOW_OD_MIN_NS 48000
`define SWR_PRES_HIGH_STD_NS 30000
`define SWR_PRES_HIGH_OD_NS 3000
`define SWR_PRES_LOW_STD_NS 120000
`define SWR_PRES_LOW_OD_NS 12000
`define SWR_WSAMP_STD_NS 30000
`define SWR_WSAMP_OD_NS 3000
`define SWR_RDRIVE_STD_NS 30000
`define SWR_RDRIVE_OD_NS 3000

`define SWR_CMD_READ 8'h33
`define SWR_CMD_SEARCH 8'hf0
`define SWR_CMD_SKIP 8'h3c
`define SWR_CRC_POLY 8'h8c
`define SWR_CMD_LAST_BIT 6'h07
`define SWR_ROM_LAST_BIT 6'h3f
`define SWR_CNT_MAX 16'hffff

`endif

//--- verilog/swr_rom_slave.sv
// Slave end of a single-wire open-drain bus returning a 64-bit registration number.
// Assumes an external pull-up and a testbench that resolves the wire from dq_oe.
//
// Summary of operation
// - Read command shifts out family code, serial number and check byte.
// - Search runs three slots per bit, least significant bit first.
// - Search slots one and two give true then inverted bit.
// - Third search slot: mismatching device drops out until reset.
// - Overdrive skip command sets the fast speed flag.
// - Reset low of standard minimum clears the fast speed flag.
// - In overdrive a short reset keeps the fast speed flag.
// - Standard timing unless fast; fast timing applies to all waveforms.
// - Master starts all slots; slave originates only presence.
// - After reset rise, wait presence delay then drive presence low.
// - One bit per slot; falling edge starts the slot timer.
// - Master allows recovery between slots.
// - Commands and data move least significant bit first.
// - Each low period is classed as slot or reset by length.
// - Read zero drives low for a timed period; read one never drives.
`timescale 1ns/1ps
`default_nettype none
`include "swr_regs.svh"

module swr_rom_slave #(
  parameter logic [7:0] FAMILY_CODE = 8'h5a, // Arbitrary value
  parameter logic [47:0] SERIAL_NUMBER = 48'h0123456789ab, // Arbitrary value
  parameter int unsigned STD_RST_CYC = `SWR_CYC_UP(`SWR_RESET_LOW_STD_NS)
)(
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic dq_i,
  output var logic dq_o,
  output var logic dq_oe,
  output var logic fast_speed_flag
);
  import swr_pkg::*;

  function automatic logic [7:0] swr_crc8(input logic [55:0] d);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 0; i < 56; i++) begin
      if (c[0] ^ d[i]) begin
        c = (c >> 1) ^ `SWR_CRC_POLY;
      end else begin
        c = c >> 1;
      end
    end
    return c;
  endfunction

  function automatic logic [15:0] swr_pick(input logic f, input logic [15:0] s,
    input logic [15:0] o);
    return f ? o : s;
  endfunction

  localparam logic [55:0] ROM_BODY = {SERIAL_NUMBER, FAMILY_CODE};
  // Bit 0 is the family code LSB, bit 63 the check byte MSB
  localparam logic [63:0] ROM = {swr_crc8(ROM_BODY), ROM_BODY};
  localparam logic [15:0] STD_RST = 16'(STD_RST_CYC);
  localparam logic [15:0] OD_RST_MIN = 16'(`SWR_CYC_UP(`SWR_RESET_LOW_OD_MIN_NS));
  localparam logic [15:0] OD_RST_MAX = 16'(`SWR_CYC_UP(`SWR_RESET_LOW_OD_MAX_NS));
  localparam logic [15:0] PDH_STD = 16'(`SWR_CYC_UP(`SWR_PRES_HIGH_STD_NS));
  localparam logic [15:0] PDH_OD = 16'(`SWR_CYC_UP(`SWR_PRES_HIGH_OD_NS));
  localparam logic [15:0] PDL_STD = 16'(`SWR_CYC_UP(`SWR_PRES_LOW_STD_NS));
  localparam logic [15:0] PDL_OD = 16'(`SWR_CYC_UP(`SWR_PRES_LOW_OD_NS));
  localparam logic [15:0] WS_STD = 16'(`SWR_CYC_UP(`SWR_WSAMP_STD_NS));
  localparam logic [15:0] WS_OD = 16'(`SWR_CYC_UP(`SWR_WSAMP_OD_NS));
  localparam logic [15:0] RD_STD = 16'(`SWR_CYC_UP(`SWR_RDRIVE_STD_NS));
  localparam logic [15:0] RD_OD = 16'(`SWR_CYC_UP(`SWR_RDRIVE_OD_NS));
  // Longest wait from a slot's edge to its sample point, for the checks below
  localparam int SLOT_SPAN = `SWR_CYC_UP(`SWR_WSAMP_STD_NS);

  swr_state_s st_reg;
  swr_state_s st_next;
  logic fell;
  logic rose;
  logic samp;
  logic cur;
  logic drive_zero;
  logic cmd_done;
  logic [7:0] cmd_word;

  // Edges are taken from the second synchroniser stage onward only
  assign fell = st_reg.prev && !st_reg.sync2;
  assign rose = !st_reg.prev && st_reg.sync2;
  assign cur = ROM[st_reg.bitn];
  // Slot timer sample point, fast or standard
  assign samp = st_reg.ph == SWR_PH_LOW && st_reg.cnt == swr_pick(st_reg.fast, WS_STD, WS_OD);
  assign cmd_word = {st_reg.sync2, st_reg.cmd[7:1]};
  assign cmd_done = samp && st_reg.mode == SWR_M_CMD && st_reg.bitn == `SWR_CMD_LAST_BIT;
  // True bit first, then its complement
  assign drive_zero = (st_reg.mode == SWR_M_READ && !cur) ||
                      (st_reg.mode == SWR_M_SEARCH && st_reg.tri_pos == 2'h0 && !cur) ||
                      (st_reg.mode == SWR_M_SEARCH && st_reg.tri_pos == 2'h1 && cur);

  always_comb begin
    st_next = st_reg;
    st_next.sync1 = dq_i;
    st_next.sync2 = st_reg.sync1;
    st_next.prev = st_reg.sync2;
    if (st_reg.cnt != `SWR_CNT_MAX) begin
      st_next.cnt = st_reg.cnt + 16'h0001;
    end
    unique case (st_reg.ph)
      SWR_PH_IDLE: begin
        if (fell) begin
          st_next.ph = SWR_PH_LOW;
          st_next.cnt = 16'h0000;
          st_next.oe = drive_zero;
        end
      end
      SWR_PH_LOW: begin
        if (st_reg.oe && st_reg.cnt == swr_pick(st_reg.fast, RD_STD, RD_OD)) begin
          st_next.oe = 1'b0;
        end
        if (samp) begin
          unique case (st_reg.mode)
            SWR_M_CMD: begin
              st_next.cmd = cmd_word;
              st_next.bitn = st_reg.bitn + 6'h01;
              if (cmd_done) begin
                st_next.bitn = 6'h00;
                st_next.tri_pos = 2'h0;
                if (cmd_word == `SWR_CMD_READ) begin
                  st_next.mode = SWR_M_READ;
                end else if (cmd_word == `SWR_CMD_SEARCH) begin
                  st_next.mode = SWR_M_SEARCH;
                end else if (cmd_word == `SWR_CMD_SKIP) begin
                  st_next.fast = 1'b1;
                  st_next.mode = SWR_M_DEAD;
                end else begin
                  st_next.mode = SWR_M_DEAD;
                end
              end
            end
            SWR_M_READ: begin
              st_next.bitn = st_reg.bitn + 6'h01;
              if (st_reg.bitn == `SWR_ROM_LAST_BIT) begin
                st_next.mode = SWR_M_DEAD;
              end
            end
            SWR_M_SEARCH: begin
              if (st_reg.tri_pos != 2'h2) begin
                st_next.tri_pos = st_reg.tri_pos + 2'h1;
              end else if (st_reg.sync2 != cur) begin
                st_next.mode = SWR_M_DEAD;
              end else begin
                st_next.tri_pos = 2'h0;
                st_next.bitn = st_reg.bitn + 6'h01;
                if (st_reg.bitn == `SWR_ROM_LAST_BIT) begin
                  st_next.mode = SWR_M_DEAD;
                end
              end
            end
            SWR_M_DEAD: begin
            end
          endcase
          // A short write-one is already over, so the slot ends at its sample point
          if (st_reg.sync2) begin
            st_next.ph = SWR_PH_IDLE;
          end
        end
        // Length of the low decides slot or reset a rise before the
        // sample point only ends the low while the slot timer keeps running
        if (rose && st_reg.cnt >= swr_pick(st_reg.fast, WS_STD, WS_OD)) begin
          st_next.oe = 1'b0;
          st_next.cnt = 16'h0000;
          if (st_reg.cnt >= STD_RST) begin
            st_next.fast = 1'b0;
            st_next.ph = SWR_PH_PWAIT;
          end else if (st_reg.fast && st_reg.cnt >= OD_RST_MIN) begin
            st_next.ph = SWR_PH_PWAIT;
          end else begin
            // Idle again once the line is high; the next edge is a new slot
            st_next.ph = SWR_PH_IDLE;
          end
        end
      end
      SWR_PH_PWAIT: begin
        if (st_reg.cnt == swr_pick(st_reg.fast, PDH_STD, PDH_OD)) begin
          st_next.ph = SWR_PH_PDRIVE;
          st_next.cnt = 16'h0000;
          st_next.oe = 1'b1;
        end
      end
      SWR_PH_PDRIVE: begin
        // Our own low is not a slot, so falling edges are not looked at here
        if (st_reg.cnt == swr_pick(st_reg.fast, PDL_STD, PDL_OD)) begin
          st_next.ph = SWR_PH_IDLE;
          st_next.oe = 1'b0;
          st_next.mode = SWR_M_CMD;
          st_next.bitn = 6'h00;
          st_next.tri_pos = 2'h0;
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_reg <= '{sync1: 1'b1, sync2: 1'b1, prev: 1'b1, oe: 1'b0, fast: 1'b0,
                  mode: SWR_M_DEAD, ph: SWR_PH_IDLE, cnt: 16'h0000, bitn: 6'h00,
                  tri_pos: 2'h0, cmd: 8'h00};
    end else if (ce) begin
      st_reg <= st_next;
    end
  end

  // Open drain: the output level is always low, only the enable moves
  assign dq_o = 1'b0;
  assign dq_oe = st_reg.oe;
  assign fast_speed_flag = st_reg.fast;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence s_long_low_rise;
    ce && rose && st_reg.ph == SWR_PH_LOW && st_reg.cnt >= STD_RST;
  endsequence
  sequence s_fast_low_rise;
    ce && rose && st_reg.ph == SWR_PH_LOW && st_reg.fast && st_reg.cnt < STD_RST &&
    st_reg.cnt >= OD_RST_MIN && st_reg.cnt <= OD_RST_MAX;
  endsequence

  a_skip_sets_fast: assert property (
    ce && cmd_done && cmd_word == `SWR_CMD_SKIP |=> st_reg.fast)
    else $error("overdrive skip did not set fast flag");
  a_long_reset_std: assert property (
    s_long_low_rise |=> !st_reg.fast && st_reg.ph == SWR_PH_PWAIT)
    else $error("long reset did not clear fast flag");
  a_fast_reset_keep: assert property (
    s_fast_low_rise |=> st_reg.fast && st_reg.ph == SWR_PH_PWAIT)
    else $error("short overdrive reset lost fast flag");
  a_presence_drive: assert property (
    st_reg.ph == SWR_PH_PDRIVE |-> dq_oe)
    else $error("presence low not driven");
  a_drive_origin: assert property (
    dq_oe |-> st_reg.ph inside {SWR_PH_PDRIVE, SWR_PH_LOW})
    else $error("line driven outside slot or presence");
  // An early rise must not cut the slot short of its sample point
  a_slot_sampled: assert property (
    ce && fell && st_reg.ph == SWR_PH_IDLE |=> ##[0:SLOT_SPAN] samp)
    else $error("slot ended without a sample point");
  a_read_zero_low: assert property (
    ce && fell && st_reg.ph == SWR_PH_IDLE && st_reg.mode == SWR_M_READ && !cur |=> dq_oe)
    else $error("read zero not driven");
  a_read_one_quiet: assert property (
    ce && fell && st_reg.ph == SWR_PH_IDLE && st_reg.mode == SWR_M_READ && cur |=> !dq_oe)
    else $error("read one drove the line");
  a_search_comp_bit: assert property (
    ce && fell && st_reg.ph == SWR_PH_IDLE && st_reg.mode == SWR_M_SEARCH &&
    st_reg.tri_pos == 2'h1 |=> dq_oe == $past(cur))
    else $error("search complement slot wrong");
  a_search_dropout: assert property (
    ce && samp && st_reg.mode == SWR_M_SEARCH && st_reg.tri_pos == 2'h2 &&
    st_reg.sync2 != cur |=> st_reg.mode == SWR_M_DEAD)
    else $error("mismatching device stayed in search");
  a_bad_cmd_dead: assert property (
    ce && cmd_done && !(cmd_word inside {`SWR_CMD_READ, `SWR_CMD_SEARCH, `SWR_CMD_SKIP})
    |=> st_reg.mode == SWR_M_DEAD)
    else $error("unknown command not ignored");
endmodule
`default_nettype wire
